// File: shared/fmmc_pkg.sv
// Package of constants and types for the framer mode and monitor control.
package fmmc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  // Register indices; the byte address is four times the index.
  localparam logic [9:0] FMMC_IDX_MODE = 10'h000;
  localparam logic [9:0] FMMC_IDX_LINK = 10'h001;
  localparam logic [7:0] FMMC_MODE_RST = 8'h00;
  localparam logic [7:0] FMMC_LINK_RST = 8'h00;

  // Mode control field positions.
  localparam int FMMC_M_LINE_LP = 7;
  localparam int FMMC_M_SRC_LP = 6;
  localparam int FMMC_M_ALM_HI = 5;
  localparam int FMMC_M_ALM_LO = 4;
  localparam int FMMC_M_EXT_OVH = 3;
  localparam int FMMC_M_EXT_CBIT = 2;
  localparam int FMMC_M_E3 = 1;
  localparam int FMMC_M_PARITY = 0;

  // Data link control field positions.
  localparam int FMMC_L_RX_IE = 7;
  localparam int FMMC_L_DIS = 6;
  localparam int FMMC_L_PTR_HI = 5;
  localparam int FMMC_L_PTR_LO = 3;
  localparam int FMMC_L_ABORT = 2;
  localparam int FMMC_L_FCS = 1;
  localparam int FMMC_L_MSG = 0;

  // AHB transfer type and response codes.
  localparam logic [1:0] FMMC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] FMMC_HTRANS_SEQ = 2'h3;
  localparam logic FMMC_HRESP_OKAY = 1'h0;

  // Cycles from a transmit C-bit slot to reading the synchronised pin.
  localparam logic [1:0] FMMC_CBIT_SAMPLE_DLY = 2'h3;

  // ****************************************************************
  // Types
  // ****************************************************************
  // Receiver indications, in the bit order used on the monitor pins.
  typedef struct packed {
    logic frame_bit_err;
    logic line_code_viol;
    logic parity_err;
    logic idle_code;
    logic yellow;
    logic ais;
    logic out_of_frame;
    logic loss_of_signal;
  } fmmc_alarm_t;

  // Effective framer controls after standalone overrides.
  typedef struct packed {
    logic line_loopback_en;
    logic source_loopback_en;
    logic external_overhead_insert;
    logic e3_framing_en;
    logic parity_mode;
    logic [1:0] ds3_alarm_code;
    logic e3_ais;
    logic e3_yellow;
    logic [1:0] cbit_source;
    logic nbit_from_pin;
    logic parallel_en;
    logic transparency_en;
    logic ds3_framing_off;
    logic wide_crc;
  } fmmc_ctl_t;

  // Data link transmitter states.
  typedef enum logic [1:0] {
    FMMC_DL_IDLE,
    FMMC_DL_MSG,
    FMMC_DL_FCS,
    FMMC_DL_ABORT
  } fmmc_dl_state_t;

endpackage

// File: hw/fmmc_top.sv
// Mode control registers, standalone monitor logic and overhead bit I/O.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Received C-bits or E3 N-bit shift out on the overhead clock.
// - Standalone pin forces M13, external C-bits, no E3.
// - Standalone parallel strap alone: byte ports, no transparency.
// - Both straps: transparency, no DS3 framing, NRZ on overhead clock.
// - Standalone wide CRC strap selects 32-bit CRC, else 16-bit.
// - Standalone alarm straps act like the alarm field bits.
// - Standalone turns the data pins into active-high alarm outputs.
// - Indications are levels except frame error and violation pulses.
// - Line loopback returns the undecoded receive stream to transmit.
// - Source loopback feeds encoded transmit data into the decoder.
// - DS3 alarm field: normal, yellow, idle code, AIS.
// - E3 low alarm bit forces AIS, high bit yellow; AIS wins.
// - External overhead bit takes overhead from transmit serial data.
// - Parity and external C-bit bits choose the DS3 C-bit source.
// - E3 N-bit comes from the pin or the data link.
// - E3 framing bit enables E3 and overrides parity mode.
// - Parity bit: C-bit parity framing, or link interrupt enable in E3.
// - Link register ignored outside parity or E3; top bit gates interrupt.
// - Link disable forces ones; pointer marks the last buffer entry.
// - Abort halts the message, sends abort, then idle flags.
// - Send starts a message with byte interrupts; FCS bit appends check.
// - Far alarm interrupt needs parity bit and its enable.
module fmmc_top
  import fmmc_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Strap pins, asynchronous to hclk.
  input wire logic standalone_select_pin,
  input wire logic parallel_enable_strap,
  input wire logic packet_only_strap,
  input wire logic wide_crc_select,
  input wire logic alarm_strap_low,
  input wire logic alarm_strap_high,
  // Receiver side and transmit NRZ data, same clock.
  input wire fmmc_alarm_t rx_alarms,
  input wire logic rx_cbit_valid,
  input wire logic rx_cbit,
  input wire logic rx_link_int_status,
  input wire logic rx_far_alarm_int,
  input wire logic rx_far_alarm_int_en,
  input wire logic tx_serial_nrz,
  // Transmitter side, same clock.
  input wire logic tx_cbit_slot,
  input wire logic tx_link_byte_done,
  // Overhead bit pins.
  input wire logic overhead_bit_serial_in,
  output logic overhead_bit_serial_out,
  output logic rx_overhead_bit_clock,
  output logic tx_overhead_bit_clock,
  output logic tx_cbit_ext_valid,
  output logic tx_cbit_ext_bit,
  // Monitor outputs on the address/data pins.
  output logic [7:0] ad_out,
  output logic ad_oe,
  // Effective controls and data link controls.
  output fmmc_ctl_t ctl,
  output logic link_interrupt_out,
  output logic tx_link_force_ones,
  output logic [2:0] tx_link_buf_index,
  output logic tx_link_send_msg,
  output logic tx_link_send_fcs,
  output logic tx_link_send_abort,
  output logic tx_link_byte_int
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [6:0] pin_raw;
  logic [6:0] sync1_reg, sync1_next;
  logic [6:0] sync2_reg, sync2_next;
  logic sa, st_par, st_pkt, st_crc, st_alm0, st_alm1, cbit_in_s;
  assign pin_raw = {overhead_bit_serial_in, alarm_strap_high,
                    alarm_strap_low, wide_crc_select, packet_only_strap,
                    parallel_enable_strap, standalone_select_pin};
  // Each pin passes two flip-flops; only the second stage is read.
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_sync
      always_comb
      begin
        sync1_next[gi] = pin_raw[gi];
        sync2_next[gi] = sync1_reg[gi];
      end
    end
  endgenerate

  // Synchroniser registers.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  assign {cbit_in_s, st_alm1, st_alm0, st_crc, st_pkt, st_par, sa} =
    sync2_reg;

  // ****************************************************************
  // AHB-Lite register slave
  // ****************************************************************
  logic [7:0] mode_reg, mode_next;
  logic [7:0] link_reg, link_next;
  logic wr_pend_reg, wr_pend_next;
  logic [9:0] wr_idx_reg, wr_idx_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic addr_ok, wr_mode, wr_link;
  logic [9:0] a_idx;
  logic [7:0] fwd_mode, fwd_link;

  // Only aligned transfers inside the register window are taken.
  assign addr_ok = hsel && hready && htrans[1] && haddr[1:0] == 2'h0 &&
                   haddr[31:12] == 20'h00000;
  assign a_idx = haddr[11:2];
  assign wr_mode = wr_pend_reg && wr_idx_reg == FMMC_IDX_MODE;
  assign wr_link = wr_pend_reg && wr_idx_reg == FMMC_IDX_LINK;
  // Forward data of a write in its data phase to an overlapping read.
  assign fwd_mode = wr_mode ? hwdata[7:0] : mode_reg;
  assign fwd_link = wr_link ? hwdata[7:0] : link_reg;

  // Decode, store writes and prepare read data one cycle early.
  always_comb
  begin
    mode_next = wr_mode ? hwdata[7:0] : mode_reg;
    link_next = wr_link ? hwdata[7:0] : link_reg;
    wr_pend_next = addr_ok && hwrite;
    wr_idx_next = addr_ok ? a_idx : wr_idx_reg;
    hrdata_next = 32'h0000_0000;
    if (addr_ok && !hwrite && a_idx == FMMC_IDX_MODE)
      hrdata_next = {24'h000000, fwd_mode};
    else if (addr_ok && !hwrite && a_idx == FMMC_IDX_LINK)
      hrdata_next = {24'h000000, fwd_link};
  end

  // Bus registers; both control registers clear at reset.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_reg <= FMMC_MODE_RST;
      link_reg <= FMMC_LINK_RST;
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 10'h000;
      hrdata_reg <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= FMMC_HRESP_OKAY;
    end
    else
    begin
      mode_reg <= mode_next;
      link_reg <= link_next;
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg <= wr_idx_next;
      hrdata_reg <= hrdata_next;
      hreadyout <= 1'b1;
      hresp <= FMMC_HRESP_OKAY;
    end
  end
  assign hrdata = hrdata_reg;

  // ****************************************************************
  // Effective framer controls
  // ****************************************************************
  fmmc_ctl_t ctl_next;
  logic e3_on, par_on, link_active;
  logic [1:0] alm;
  // Standalone forces DS3 M13 framing; E3 overrides parity mode.
  assign e3_on = mode_reg[FMMC_M_E3] && !sa;
  assign par_on = mode_reg[FMMC_M_PARITY] && !sa && !e3_on;
  // Alarm straps replace the alarm field with the same encoding.
  assign alm = sa ? {st_alm1, st_alm0} :
               {mode_reg[FMMC_M_ALM_HI], mode_reg[FMMC_M_ALM_LO]};
  assign link_active = par_on || e3_on;

  // Build the control word sent to the framer datapath.
  always_comb
  begin
    ctl_next.line_loopback_en = mode_reg[FMMC_M_LINE_LP];
    ctl_next.source_loopback_en = mode_reg[FMMC_M_SRC_LP];
    ctl_next.external_overhead_insert =
      mode_reg[FMMC_M_EXT_OVH];
    ctl_next.e3_framing_en = e3_on;
    ctl_next.parity_mode = par_on;
    ctl_next.ds3_alarm_code = e3_on ? 2'h0 : alm;
    ctl_next.e3_ais = e3_on && alm[0];
    ctl_next.e3_yellow = e3_on && alm[1] && !alm[0];
    // Code: 0 serial, 1 pin, 2 internal, 3 internal except CP/FEBE.
    ctl_next.cbit_source = e3_on ? 2'h0 :
      {par_on, mode_reg[FMMC_M_EXT_CBIT] || sa};
    ctl_next.nbit_from_pin = e3_on && mode_reg[FMMC_M_EXT_CBIT];
    ctl_next.parallel_en = sa && st_par;
    ctl_next.transparency_en = sa && st_par && st_pkt;
    ctl_next.ds3_framing_off = sa && st_par && st_pkt;
    ctl_next.wide_crc = sa && st_crc;
  end

  // Control word register.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctl <= '0;
    else
      ctl <= ctl_next;
  end

  // ****************************************************************
  // Monitor outputs and link interrupt
  // ****************************************************************
  logic [7:0] ad_next;
  logic ad_oe_next, link_int_next;
  // Indications go straight to the pins; pulses arrive already shaped.
  always_comb
  begin
    ad_next = sa ? rx_alarms : 8'h00;
    ad_oe_next = sa;
    link_int_next = 1'b0;
    if (par_on || (e3_on && mode_reg[FMMC_M_PARITY]))
      link_int_next = rx_link_int_status && link_reg[FMMC_L_RX_IE];
    if (par_on && rx_far_alarm_int && rx_far_alarm_int_en)
      link_int_next = 1'b1;
  end

  // Monitor and interrupt registers.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ad_out <= 8'h00;
      ad_oe <= 1'b0;
      link_interrupt_out <= 1'b0;
    end
    else
    begin
      ad_out <= ad_next;
      ad_oe <= ad_oe_next;
      link_interrupt_out <= link_int_next;
    end
  end

  // ****************************************************************
  // Serial overhead bit output and input
  // ****************************************************************
  logic cbo_next, rxclk_next, txclk_next, ext_v_next, ext_b_next;
  logic [1:0] smp_cnt_reg, smp_cnt_next;

  // Data and its clock change together; the far side samples at the fall.
  always_comb
  begin
    cbo_next = rx_cbit_valid ? rx_cbit : overhead_bit_serial_out;
    rxclk_next = rx_cbit_valid;
    if (ctl.ds3_framing_off)
      rxclk_next = tx_serial_nrz;
    txclk_next = tx_cbit_slot;
    smp_cnt_next = smp_cnt_reg;
    ext_v_next = 1'b0;
    ext_b_next = tx_cbit_ext_bit;
    if (tx_cbit_slot)
      smp_cnt_next = FMMC_CBIT_SAMPLE_DLY;
    else if (smp_cnt_reg != 2'h0)
    begin
      smp_cnt_next = smp_cnt_reg - 2'h1;
      if (smp_cnt_reg == 2'h1)
      begin
        ext_v_next = 1'b1;
        ext_b_next = cbit_in_s;
      end
    end
  end

  // Overhead pin registers.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      overhead_bit_serial_out <= 1'b0;
      rx_overhead_bit_clock <= 1'b0;
      tx_overhead_bit_clock <= 1'b0;
      smp_cnt_reg <= 2'h0;
      tx_cbit_ext_valid <= 1'b0;
      tx_cbit_ext_bit <= 1'b0;
    end
    else
    begin
      overhead_bit_serial_out <= cbo_next;
      rx_overhead_bit_clock <= rxclk_next;
      tx_overhead_bit_clock <= txclk_next;
      smp_cnt_reg <= smp_cnt_next;
      tx_cbit_ext_valid <= ext_v_next;
      tx_cbit_ext_bit <= ext_b_next;
    end
  end

  // ****************************************************************
  // Data link transmit sequencer
  // ****************************************************************
  fmmc_dl_state_t dl_reg, dl_next;
  logic [2:0] idx_next;
  logic force_next, int_next, go_msg, go_abort;
  // Commands act on a write that sets the bit, only while the link is on.
  assign go_msg = wr_link && hwdata[FMMC_L_MSG] && link_active;
  assign go_abort = wr_link && hwdata[FMMC_L_ABORT] && link_active;

  // Idle flags, message bytes, optional check sequence, abort flag.
  always_comb
  begin
    dl_next = dl_reg;
    idx_next = tx_link_buf_index;
    int_next = 1'b0;
    force_next = link_active && link_reg[FMMC_L_DIS];
    unique case (dl_reg)
      FMMC_DL_IDLE:
      begin
        if (go_msg && !go_abort)
        begin
          dl_next = FMMC_DL_MSG;
          idx_next = 3'h0;
        end
      end
      FMMC_DL_MSG:
      begin
        if (tx_link_byte_done)
        begin
          int_next = 1'b1;
          if (tx_link_buf_index == link_reg[FMMC_L_PTR_HI:FMMC_L_PTR_LO])
            dl_next = link_reg[FMMC_L_FCS] ? FMMC_DL_FCS :
                      FMMC_DL_IDLE;
          else
            idx_next = tx_link_buf_index + 3'h1;
        end
      end
      FMMC_DL_FCS, FMMC_DL_ABORT:
      begin
        if (tx_link_byte_done)
          dl_next = FMMC_DL_IDLE;
      end
    endcase
    if (go_abort && dl_reg != FMMC_DL_IDLE)
      dl_next = FMMC_DL_ABORT;
    if (!link_active)
      dl_next = FMMC_DL_IDLE;
  end

  // Data link registers.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dl_reg <= FMMC_DL_IDLE;
      tx_link_buf_index <= 3'h0;
      tx_link_force_ones <= 1'b0;
      tx_link_byte_int <= 1'b0;
      tx_link_send_msg <= 1'b0;
      tx_link_send_fcs <= 1'b0;
      tx_link_send_abort <= 1'b0;
    end
    else
    begin
      dl_reg <= dl_next;
      tx_link_buf_index <= idx_next;
      tx_link_force_ones <= force_next;
      tx_link_byte_int <= int_next;
      tx_link_send_msg <= dl_next == FMMC_DL_MSG;
      tx_link_send_fcs <= dl_next == FMMC_DL_FCS;
      tx_link_send_abort <= dl_next == FMMC_DL_ABORT;
    end
  end

endmodule // fmmc_top
`default_nettype wire

// File: dv/fmmc_top_props.sv
// Concurrent checks on the ports of the mode and monitor control block.
`timescale 1ns/1ns
`default_nettype none
module fmmc_props
  import fmmc_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Bus signals.
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Overhead bits and straps.
  input wire logic rx_cbit_valid,
  input wire logic rx_cbit,
  input wire logic overhead_bit_serial_out,
  input wire logic rx_overhead_bit_clock,
  input wire logic tx_cbit_slot,
  input wire logic tx_overhead_bit_clock,
  input wire logic tx_cbit_ext_valid,
  input wire logic alarm_strap_low,
  input wire logic alarm_strap_high,
  // Monitor pins and controls.
  input wire fmmc_alarm_t rx_alarms,
  input wire logic [7:0] ad_out,
  input wire logic ad_oe,
  input wire fmmc_ctl_t ctl,
  input wire logic tx_link_byte_done,
  input wire logic tx_link_send_msg,
  input wire logic tx_link_byte_int
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Slot then its clock.
  sequence s_tx_clock;
    tx_cbit_slot ##1 tx_overhead_bit_clock;
  endsequence
  // Bit then its clock.
  sequence s_rx_bit;
    rx_cbit_valid && !ctl.ds3_framing_off ##1 rx_overhead_bit_clock;
  endsequence

  a_ready_okay: assert property ($past(hresetn) |-> hreadyout && hresp == FMMC_HRESP_OKAY)
    else $error("bus not ready");
  a_rdata_idle: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
    else $error("read data stuck");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_rx_bit_out: assert property (s_rx_bit |-> overhead_bit_serial_out == $past(rx_cbit))
    else $error("rx bit not shifted out");
  a_tx_slot_take: assert property (s_tx_clock |-> ##3 tx_cbit_ext_valid)
    else $error("tx bit not taken");
  a_mon_copy: assert property (ad_oe && $past(ad_oe) |-> ad_out == $past(rx_alarms))
    else $error("monitor pins wrong");
  a_mon_quiet: assert property (!ad_oe |-> ad_out == 8'h00)
    else $error("monitor pins not idle");
  a_sa_ctl: assert property (ad_oe && $past(ad_oe) |-> ctl.cbit_source == 2'h1 && !ctl.e3_framing_en && !ctl.parity_mode)
    else $error("standalone not forced");
  a_sa_alarm: assert property (ad_oe && $past(ad_oe) |-> ctl.ds3_alarm_code[0] == $past(alarm_strap_low, 3) && ctl.ds3_alarm_code[1] == $past(alarm_strap_high, 3))
    else $error("alarm code wrong");
  a_e3_alarm: assert property (ctl.e3_ais |-> !ctl.e3_yellow)
    else $error("yellow with AIS");
  a_byte_int: assert property (tx_link_byte_int |-> $past(tx_link_byte_done) && $past(tx_link_send_msg))
    else $error("stray byte interrupt");
endmodule // fmmc_props

// Attach the checker to the top module.
bind fmmc_top fmmc_props u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .rx_cbit_valid(rx_cbit_valid), .rx_cbit(rx_cbit),
  .overhead_bit_serial_out(overhead_bit_serial_out),
  .rx_overhead_bit_clock(rx_overhead_bit_clock),
  .tx_cbit_slot(tx_cbit_slot), .tx_overhead_bit_clock(tx_overhead_bit_clock),
  .tx_cbit_ext_valid(tx_cbit_ext_valid), .alarm_strap_low(alarm_strap_low),
  .alarm_strap_high(alarm_strap_high), .rx_alarms(rx_alarms),
  .ad_out(ad_out), .ad_oe(ad_oe), .ctl(ctl),
  .tx_link_byte_done(tx_link_byte_done),
  .tx_link_send_msg(tx_link_send_msg), .tx_link_byte_int(tx_link_byte_int)
);
`default_nettype wire

// File: dv/fmmc_far_model.sv
// Model of the outside overhead bit formatter and alarm counter.
`timescale 1ns/1ns
`default_nettype none
module fmmc_far_model
  import fmmc_pkg::*;
#(
  parameter logic [7:0] PAT = 8'h96
)
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Pins seen from outside.
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire logic rx_dat,
  input wire logic ferr,
  output logic cbit_in,
  // Collected results.
  output logic [7:0] rx_bits,
  output logic [7:0] ferr_cnt
);
  logic [2:0] idx;
  logic [1:0] tq;
  logic ferr_q;

  // The next bit waits on the pin ahead of its slot clock.
  assign cbit_in = PAT[idx];

  // Advance after each clock, capture received bits, count error pulses.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      idx <= 3'h0;
      tq <= 2'h0;
      ferr_q <= 1'b0;
      rx_bits <= 8'h00;
      ferr_cnt <= 8'h00;
    end
    else
    begin
      tq <= {tq[0], tx_clk};
      if (tq[1])
        idx <= idx + 3'h1;
      if (rx_clk)
        rx_bits <= {rx_bits[6:0], rx_dat};
      ferr_q <= ferr;
      if (ferr && !ferr_q)
        ferr_cnt <= ferr_cnt + 8'h01;
    end
  end
endmodule // fmmc_far_model
`default_nettype wire

// File: dv/fmmc_bench.sv
// Self-checking bench for the mode and monitor control block.
`timescale 1ns/1ns
`default_nettype none
module fmmc_bench
  import fmmc_pkg::*;
;
  localparam logic [7:0] TX_PAT = 8'h96;
  localparam logic [7:0] RX_PAT = 8'hb4;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic sa, par, pkt, crc, al, ah, rcv, rcb, rlis, rfa, rfae, nrz, slot, done;
  logic cin, cout, rxck, txck, xv, xb, adoe, lio, f1, smsg, sfcs, sab, bint;
  fmmc_alarm_t alm;
  logic [7:0] ad, m, ext_bits, rx_bits, ferr_cnt;
  logic [2:0] bidx;
  fmmc_ctl_t ctl;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_int = 0;

  // ****************************************************************
  // Design and far side
  // ****************************************************************
  fmmc_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .standalone_select_pin(sa),
    .parallel_enable_strap(par), .packet_only_strap(pkt),
    .wide_crc_select(crc), .alarm_strap_low(al), .alarm_strap_high(ah),
    .rx_alarms(alm), .rx_cbit_valid(rcv), .rx_cbit(rcb),
    .rx_link_int_status(rlis), .rx_far_alarm_int(rfa),
    .rx_far_alarm_int_en(rfae), .tx_serial_nrz(nrz), .tx_cbit_slot(slot),
    .tx_link_byte_done(done), .overhead_bit_serial_in(cin),
    .overhead_bit_serial_out(cout), .rx_overhead_bit_clock(rxck),
    .tx_overhead_bit_clock(txck), .tx_cbit_ext_valid(xv),
    .tx_cbit_ext_bit(xb), .ad_out(ad), .ad_oe(adoe), .ctl(ctl),
    .link_interrupt_out(lio), .tx_link_force_ones(f1),
    .tx_link_buf_index(bidx), .tx_link_send_msg(smsg),
    .tx_link_send_fcs(sfcs), .tx_link_send_abort(sab),
    .tx_link_byte_int(bint)
  );
  fmmc_far_model #(.PAT(TX_PAT)) u_far (
    .hclk(hclk), .hresetn(hresetn), .tx_clk(txck), .rx_clk(rxck),
    .rx_dat(cout), .ferr(ad[7]), .cbit_in(cin), .rx_bits(rx_bits),
    .ferr_cnt(ferr_cnt)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task wrap_up();
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // One single transfer: address phase, then data phase.
  task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= FMMC_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task wr(input logic [9:0] i, input logic [7:0] d);
    xfer({20'h0, i, 2'h0}, 1'b1, {24'h0, d});
  endtask

  task rdchk(input string n, input logic [9:0] i, input logic [7:0] e);
    xfer({20'h0, i, 2'h0}, 1'b0, 32'h0);
    chk(n, {24'h0, e}, rd);
  endtask

  task byte_done();
    done <= 1'b1;
    @(posedge hclk);
    done <= 1'b0;
    tick(3);
  endtask

  // Clock source.
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Collects taken bits and byte interrupts; ends a hung run.
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (xv === 1'b1)
      ext_bits <= {xb, ext_bits[7:1]};
    if (bint === 1'b1)
      n_int <= n_int + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, sa, par, pkt} = '0;
    {crc, al, ah, rcv, rcb, rlis, rfa, rfae, nrz, slot, done} = '0;
    hsize = 3'h2;
    alm = 8'h00;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    tick(2);
    // Reset values, an unmapped place and read-back.
    rdchk("mode_reset", FMMC_IDX_MODE, FMMC_MODE_RST);
    rdchk("link_reset", FMMC_IDX_LINK, FMMC_LINK_RST);
    xfer(32'h8, 1'b1, 32'hff);
    xfer(32'h8, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
    wr(FMMC_IDX_MODE, 8'ha5);
    wr(FMMC_IDX_LINK, 8'h5a);
    rdchk("mode_back", FMMC_IDX_MODE, 8'ha5);
    rdchk("link_back", FMMC_IDX_LINK, 8'h5a);
    tick(2);
    chk("force_ones", 32'h1, f1);
    wr(FMMC_IDX_MODE, 8'h00);
    tick(2);
    chk("link_ignored", 32'h0, f1);
    // Every alarm code and overhead bit source, in both framings.
    for (int i = 0; i < 16; i++)
    begin
      m = {i[1:0], i[3:2], i[3:0]};
      wr(FMMC_IDX_MODE, m);
      tick(2);
      chk("loops", {m[7], m[6], m[3], m[1], m[0] & ~m[1]}, {ctl.line_loopback_en, ctl.source_loopback_en, ctl.external_overhead_insert, ctl.e3_framing_en, ctl.parity_mode});
      if (m[1])
        chk("e3_ctl", {m[4], m[5] & ~m[4], m[2]}, {ctl.e3_ais, ctl.e3_yellow, ctl.nbit_from_pin});
      else
        chk("ds3_ctl", {m[5:4], m[0], m[2]}, {ctl.ds3_alarm_code, ctl.cbit_source});
    end
    // Message of two bytes with check sequence, then an abort.
    wr(FMMC_IDX_MODE, 8'h01);
    wr(FMMC_IDX_LINK, 8'h0b);
    tick(2);
    chk("msg_start", 32'h8, {smsg, bidx});
    byte_done();
    chk("msg_next", 32'h9, {smsg, bidx});
    byte_done();
    chk("fcs_phase", 32'h1, {smsg, sfcs});
    byte_done();
    chk("msg_idle", 32'h0, {smsg, sfcs, sab});
    chk("byte_ints", 32'h2, n_int);
    wr(FMMC_IDX_LINK, 8'h39);
    tick(2);
    byte_done();
    wr(FMMC_IDX_LINK, 8'h3d);
    tick(2);
    chk("abort", 32'h1, {smsg, sab});
    byte_done();
    chk("abort_end", 32'h0, {smsg, sab});
    wr(FMMC_IDX_MODE, 8'h00);
    wr(FMMC_IDX_LINK, 8'h01);
    tick(2);
    chk("msg_refused", 32'h0, smsg);
    // Link interrupt gating.
    wr(FMMC_IDX_MODE, 8'h01);
    wr(FMMC_IDX_LINK, 8'h80);
    rlis <= 1'b1;
    tick(3);
    chk("rx_link_int", 32'h1, lio);
    rlis <= 1'b0;
    rfa <= 1'b1;
    rfae <= 1'b1;
    tick(3);
    chk("far_int", 32'h1, lio);
    wr(FMMC_IDX_MODE, 8'h03);
    tick(3);
    chk("far_int_e3", 32'h0, lio);
    rlis <= 1'b1;
    tick(3);
    chk("e3_link_int", 32'h1, lio);
    wr(FMMC_IDX_MODE, 8'h02);
    tick(3);
    chk("e3_int_off", 32'h0, lio);
    {rlis, rfa, rfae} <= 3'h0;
    wr(FMMC_IDX_MODE, 8'h00);
    // Received overhead bits out, outside bits in.
    for (int j = 7; j >= 0; j--)
    begin
      rcb <= RX_PAT[j];
      rcv <= 1'b1;
      @(posedge hclk);
      rcv <= 1'b0;
      tick(2);
    end
    tick(2);
    chk("rx_serial", RX_PAT, rx_bits);
    for (int j = 0; j < 8; j++)
    begin
      slot <= 1'b1;
      @(posedge hclk);
      slot <= 1'b0;
      tick(5);
    end
    tick(4);
    chk("tx_serial", TX_PAT, ext_bits);
    // Standalone straps, monitor pins and frame error pulses.
    sa <= 1'b1;
    par <= 1'b1;
    alm <= 8'h5a;
    for (int k = 0; k < 8; k++)
    begin
      pkt <= k[0];
      crc <= k[1];
      al <= k[1];
      ah <= k[2];
      nrz <= k[2];
      tick(6);
      chk("sa_mode", {1'b1, k[0], k[0], k[1], 2'h1, k[2], k[1], 2'h0}, {ctl.parallel_en, ctl.transparency_en, ctl.ds3_framing_off, ctl.wide_crc, ctl.cbit_source, ctl.ds3_alarm_code, ctl.e3_framing_en, ctl.parity_mode});
      if (k[0])
        chk("nrz_out", k[2], rxck);
    end
    chk("monitor", {1'b1, 8'h5a}, {adoe, ad});
    for (int j = 0; j < 3; j++)
    begin
      alm <= 8'hda;
      @(posedge hclk);
      alm <= 8'h5a;
      tick(2);
    end
    tick(2);
    chk("frame_errs", 32'h3, ferr_cnt);
    sa <= 1'b0;
    tick(6);
    chk("monitor_off", 32'h0, {adoe, ad});
    wrap_up();
  end
endmodule // fmmc_bench
`default_nettype wire
